// ---- core/eeprom_emul_pkg.sv ----
// constants used by the serial slave unit and the protection logic
// assumes: nothing beyond a SystemVerilog elaborator
package eeprom_emul_pkg;

    // --------------------------------------------------------------
    // control byte layout
    // --------------------------------------------------------------
    localparam logic [3:0] PREFIX_MEMORY  = 4'hA;
    localparam logic [3:0] PREFIX_PROTECT = 4'h6;
    localparam int         CTRL_PREFIX_HI = 7;
    localparam int         CTRL_PREFIX_LO = 4;
    localparam int         CTRL_DSEL_HI   = 3;
    localparam int         CTRL_DSEL_LO   = 1;
    localparam int         CTRL_RW_BIT    = 0;

    // --------------------------------------------------------------
    // addressing and timing
    // --------------------------------------------------------------
    localparam int         PAGE_BYTES     = 128;
    localparam int         ADDR_W         = 11;
    localparam logic [6:0] PAGE_OFS_MASK  = 7'h7F;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] ACK_SLOT       = 4'h8;
    localparam logic [3:0] BIT_RESET      = 4'h0;
    localparam logic       WP_MODE_HW     = 1'b0;
    localparam logic       WP_MODE_SW     = 1'b1;

endpackage : eeprom_emul_pkg

// ---- core/flash_interface_unit.sv ----
// flash interface unit: arbitrates flash access with an outside arbiter
// assumes: all inputs are on clk_in; program_busy_in comes from the flash
`timescale 1ns/1ps
`default_nettype none

module flash_interface_unit
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // from serial slave unit (already synchronised)
    input  wire logic slave_req_in,
    input  wire logic program_pending_in,
    // outside arbiter and flash
    input  wire logic flash_access_grant_in,
    input  wire logic program_busy_in,
    output logic      flash_access_request_out,
    output logic      slave_grant_out
);

    typedef struct packed
    {
        logic req;
        logic hold;
        logic grant;
    } fiu_state_type;

    fiu_state_type st_r;
    fiu_state_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // keep requesting after a write/protect set until programming is done
        if (slave_req_in && program_pending_in)
        begin
            st_nxt.hold = 1'b1;
        end
        else if (!slave_req_in && st_r.hold && !program_busy_in && !program_pending_in)
        begin
            st_nxt.hold = 1'b0;
        end
        st_nxt.req = slave_req_in || st_nxt.hold || program_busy_in;
        // no new grant while a program is running
        st_nxt.grant = slave_req_in && flash_access_grant_in && st_r.req
                       && !program_busy_in && !(st_r.hold && !st_r.grant);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign flash_access_request_out = st_r.req;
    assign slave_grant_out          = st_r.grant;

endmodule : flash_interface_unit

`default_nettype wire

// ---- core/eeprom_emul_protect_arbiter.sv ----
// serial eeprom emulation front end: serial slave unit on scl_in, arbitration on clk_in
// assumes: open-drain sda resolved outside; flash read data valid before the byte is sent
`timescale 1ns/1ps
`default_nettype none

module eeprom_emul_protect_arbiter
#(
    parameter logic WP_MODE = 1'b0,
    parameter int   ADDR_W  = eeprom_emul_pkg::ADDR_W
)
(
    // system clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // serial link (scl is the link clock)
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_out,
    // configuration pins
    input  wire logic [2:0]        dev_select_in,
    input  wire logic              protect_pin_in,
    // outside flash arbiter
    output logic                   flash_access_request_out,
    input  wire logic              flash_access_grant_in,
    // flash data path
    input  wire logic              program_busy_in,
    input  wire logic [7:0]        read_data_in,
    output logic [ADDR_W-1:0]      read_addr_out,
    output logic                   write_allowed_out,
    output logic                   protect_reg_out
);

    // ------------------------------------------------------------------
    // serial slave state (scl domain)
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        S_IDLE  = 3'b000,
        S_CTRL  = 3'b001,
        S_CACK  = 3'b011,
        S_RDATA = 3'b010,
        S_RACK  = 3'b110,
        S_WBYTE = 3'b111,
        S_WACK  = 3'b101
    } slave_mode_type;

    typedef struct packed
    {
        slave_mode_type          mode;
        logic [3:0]              bitcnt;
        logic [7:0]              shift;
        logic [ADDR_W-1:0]       addr;
        logic                    req;
        logic                    is_write;
        logic                    prot_set_tgl;
        logic                    write_tgl;
        logic                    ack_now;
        logic                    start_seen;
        logic                    stop_seen;
        logic [1:0]              gnt_sync;
    } scl_state_type;

    typedef struct packed
    {
        logic [1:0]              req_sync;
        logic [1:0]              prot_sync;
        logic [1:0]              wr_sync;
        logic [1:0]              pin_sync;
        logic                    prot_seen;
        logic                    wr_seen;
        logic                    protect_reg;
        logic                    pending;
        logic                    prog_seen;
    } sys_state_type;

    scl_state_type sl_r;
    scl_state_type sl_nxt;
    sys_state_type sy_r;
    sys_state_type sy_nxt;

    logic start_tgl_r;
    logic stop_tgl_r;
    logic start_evt;
    logic stop_evt;
    logic tx_bit_r;
    logic slave_req_lvl;
    logic slave_grant;
    logic busy_lvl_r;
    logic busy_sync_r;
    logic prot_reg_sync0_r;
    logic prot_reg_sync1_r;

    function automatic logic prefix_is(input logic [7:0] b, input logic [3:0] p);
        prefix_is = b[eeprom_emul_pkg::CTRL_PREFIX_HI:eeprom_emul_pkg::CTRL_PREFIX_LO] == p;
    endfunction : prefix_is

    // ------------------------------------------------------------------
    // start and stop detection, sda edges while scl high
    // ------------------------------------------------------------------
    // toggles, so the scl domain consumes each event once at its next rising edge
    always_ff @(negedge sda_in or posedge rst_in)
    begin
        if (rst_in)
            start_tgl_r <= 1'b0;
        else if (scl_in)
            start_tgl_r <= ~start_tgl_r;
    end

    always_ff @(posedge sda_in or posedge rst_in)
    begin
        if (rst_in)
            stop_tgl_r <= 1'b0;
        else if (scl_in)
            stop_tgl_r <= ~stop_tgl_r;
    end

    assign start_evt = start_tgl_r != sl_r.start_seen;
    assign stop_evt  = stop_tgl_r != sl_r.stop_seen;
    // scl stops after a stop, so the request falls as soon as the stop is seen
    assign slave_req_lvl = sl_r.req && !stop_evt;

    // ------------------------------------------------------------------
    // crossings into the scl domain
    // ------------------------------------------------------------------
    always_ff @(posedge scl_in)
    begin
        busy_lvl_r       <= program_busy_in || sy_r.pending;
        busy_sync_r      <= busy_lvl_r;
        prot_reg_sync0_r <= sy_r.protect_reg;
        prot_reg_sync1_r <= prot_reg_sync0_r;
    end

    // ------------------------------------------------------------------
    // serial slave unit: bit engine sampled on rising scl
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [7:0] byte_in;
        logic       sw_prog;
        byte_in = {sl_r.shift[6:0], sda_in};
        sw_prog = (WP_MODE == eeprom_emul_pkg::WP_MODE_SW) && prot_reg_sync1_r;
        sl_nxt = sl_r;
        // first grant flop; the falling-edge output stage is the second
        sl_nxt.gnt_sync = {1'b0, slave_grant};
        sl_nxt.ack_now = 1'b0;
        sl_nxt.start_seen = start_tgl_r;
        sl_nxt.stop_seen  = stop_tgl_r;
        if (start_evt)
        begin
            // a start always re-arms the decoder, which is how a hung bus recovers
            sl_nxt.mode   = eeprom_emul_pkg::BITS_PER_BYTE == 4'h8 ? S_CTRL : S_IDLE;
            sl_nxt.bitcnt = 4'h1;
            sl_nxt.shift  = {7'h00, sda_in};
            sl_nxt.req    = sl_r.req && !stop_evt;
        end
        else if (stop_evt)
        begin
            sl_nxt.mode = S_IDLE;
            sl_nxt.req  = 1'b0;
        end
        else
        begin
            case (sl_r.mode)
            S_CTRL:
            begin
                sl_nxt.shift  = byte_in;
                sl_nxt.bitcnt = sl_r.bitcnt + 4'h1;
                if (sl_r.bitcnt == eeprom_emul_pkg::BITS_PER_BYTE - 4'h2 &&
                    {sl_r.shift[1:0], sda_in} == dev_select_in)
                begin
                    // device select seen: request early so the grant can settle
                    sl_nxt.req = !busy_sync_r;
                end
                if (sl_r.bitcnt == eeprom_emul_pkg::BITS_PER_BYTE - 4'h1)
                begin
                    sl_nxt.is_write = !sda_in;
                    sl_nxt.mode     = S_CACK;
                    sl_nxt.bitcnt   = eeprom_emul_pkg::BIT_RESET;
                    if (byte_in[eeprom_emul_pkg::CTRL_DSEL_HI:eeprom_emul_pkg::CTRL_DSEL_LO]
                        != dev_select_in)
                        sl_nxt.mode = S_IDLE;
                    else if (busy_sync_r)
                        sl_nxt.ack_now = 1'b0;
                    else if (prefix_is(byte_in, eeprom_emul_pkg::PREFIX_MEMORY))
                        sl_nxt.ack_now = 1'b1;
                    else if (prefix_is(byte_in, eeprom_emul_pkg::PREFIX_PROTECT))
                    begin
                        if (WP_MODE == eeprom_emul_pkg::WP_MODE_SW)
                            sl_nxt.ack_now = !sw_prog;
                        else
                            sl_nxt.ack_now = 1'b1;
                        if (!sda_in && !sw_prog && WP_MODE == eeprom_emul_pkg::WP_MODE_SW)
                            sl_nxt.prot_set_tgl = ~sl_r.prot_set_tgl;
                    end
                    else
                        sl_nxt.mode = S_IDLE;
                end
            end
            S_CACK:
            begin
                // ack slot sampled; choose direction
                if (!sl_r.ack_now || tx_bit_r)
                    sl_nxt.mode = S_IDLE;
                else if (sl_r.is_write)
                    sl_nxt.mode = S_WBYTE;
                else
                    sl_nxt.mode = S_RDATA;
                sl_nxt.bitcnt = eeprom_emul_pkg::BIT_RESET;
            end
            S_WBYTE:
            begin
                // address and data bytes: payload bits only counted here, not stored anywhere;
                // after protect commands they are don't-care
                sl_nxt.bitcnt = sl_r.bitcnt + 4'h1;
                if (sl_r.bitcnt == eeprom_emul_pkg::BITS_PER_BYTE - 4'h1)
                begin
                    sl_nxt.mode    = S_WACK;
                    sl_nxt.ack_now = 1'b1;
                    sl_nxt.write_tgl = ~sl_r.write_tgl;
                end
            end
            S_WACK:
            begin
                sl_nxt.mode   = S_WBYTE;
                sl_nxt.bitcnt = eeprom_emul_pkg::BIT_RESET;
            end
            S_RDATA:
            begin
                sl_nxt.bitcnt = sl_r.bitcnt + 4'h1;
                if (sl_r.bitcnt == eeprom_emul_pkg::BITS_PER_BYTE - 4'h1)
                begin
                    sl_nxt.mode = S_RACK;
                    // step within the page, wrapping at its end
                    sl_nxt.addr = {sl_r.addr[ADDR_W-1:7],
                                   7'(sl_r.addr[6:0] + 7'h01) & eeprom_emul_pkg::PAGE_OFS_MASK};
                end
            end
            S_RACK:
            begin
                // master ack continues the burst, nack ends it
                sl_nxt.bitcnt = eeprom_emul_pkg::BIT_RESET;
                sl_nxt.mode   = sda_in ? S_IDLE : S_RDATA;
            end
            default:
            begin
                sl_nxt.mode = S_IDLE;
            end
            endcase
        end
    end

    always_ff @(posedge scl_in)
    begin
        if (rst_in)
        begin
            sl_r <= '0;
        end
        else
        begin
            sl_r <= sl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // output stage, updated on falling scl
    // ------------------------------------------------------------------
    always_ff @(negedge scl_in)
    begin
        if (rst_in)
            tx_bit_r <= 1'b1;
        else if (sl_r.mode == S_CACK)
            tx_bit_r <= !(sl_r.ack_now && sl_r.gnt_sync[0]);
        else if (sl_r.mode == S_WACK)
            tx_bit_r <= !sl_r.ack_now;
        else if (sl_r.mode == S_RDATA)
            tx_bit_r <= read_data_in[3'(eeprom_emul_pkg::BITS_PER_BYTE - 4'h1 - sl_r.bitcnt)];
        else
            tx_bit_r <= 1'b1;
    end

    assign sda_out    = 1'b0;
    assign sda_oe_out = !tx_bit_r;
    assign read_addr_out = sl_r.addr;

    // ------------------------------------------------------------------
    // system domain: protection register and program bookkeeping
    // ------------------------------------------------------------------
    always_comb
    begin
        sy_nxt = sy_r;
        sy_nxt.req_sync  = {sy_r.req_sync[0], slave_req_lvl};
        sy_nxt.prot_sync = {sy_r.prot_sync[0], sl_r.prot_set_tgl};
        sy_nxt.wr_sync   = {sy_r.wr_sync[0], sl_r.write_tgl};
        sy_nxt.pin_sync  = {sy_r.pin_sync[0], protect_pin_in};
        sy_nxt.prot_seen = sy_r.prot_sync[1];
        sy_nxt.wr_seen   = sy_r.wr_sync[1];
        if (sy_r.prot_sync[1] != sy_r.prot_seen)
        begin
            sy_nxt.protect_reg = 1'b1;
            sy_nxt.pending     = 1'b1;
        end
        else if (sy_r.wr_sync[1] != sy_r.wr_seen && write_allowed_out)
            sy_nxt.pending = 1'b1;
        else if (!sy_r.req_sync[1] && !program_busy_in && sy_r.pending && sy_r.prog_seen)
        begin
            // waits for the program to be seen; without one the request never ends
            sy_nxt.pending   = 1'b0;
            sy_nxt.prog_seen = 1'b0;
        end
        if (sy_r.pending && program_busy_in)
            sy_nxt.prog_seen = 1'b1;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            sy_r <= '0;
        else
            sy_r <= sy_nxt;
    end

    // protection table; register never clears except by power-on reset
    assign write_allowed_out = !(sy_r.pin_sync[1] ||
        (WP_MODE == eeprom_emul_pkg::WP_MODE_SW && sy_r.protect_reg));
    assign protect_reg_out   = sy_r.protect_reg;

    flash_interface_unit u_fiu
    (
        .clk_in                   (clk_in),
        .rst_in                   (rst_in),
        .slave_req_in             (sy_r.req_sync[1]),
        .program_pending_in       (sy_r.pending),
        .flash_access_grant_in    (flash_access_grant_in),
        .program_busy_in          (program_busy_in),
        .flash_access_request_out (flash_access_request_out),
        .slave_grant_out          (slave_grant)
    );

endmodule : eeprom_emul_protect_arbiter

`default_nettype wire

// ---- test/eeprom_emul_chk.sv ----
// concurrent checks on the ports of eeprom_emul_protect_arbiter
// assumes: bound to that module; scl stands still between frames
`timescale 1ns/1ps
`default_nettype none

module eeprom_emul_chk
#(
    parameter logic WP_MODE = 1'h0,
    parameter int   ADDR_W  = 11
)
(
    // clocks and reset
    input wire logic              clk_in,
    input wire logic              rst_in,
    input wire logic              scl_in,
    // watched pins
    input wire logic              sda_out,
    input wire logic              sda_oe_out,
    input wire logic              protect_pin_in,
    input wire logic              flash_access_request_out,
    input wire logic              program_busy_in,
    input wire logic [ADDR_W-1:0] read_addr_out,
    input wire logic              write_allowed_out,
    input wire logic              protect_reg_out
);
    // drive level seen while scl is high must still hold at the falling edge
    logic oe_rise_r;
    always_ff @(posedge scl_in) oe_rise_r <= sda_oe_out;

    sequence req_during_program;
        flash_access_request_out && program_busy_in;
    endsequence
    sequence program_running;
        program_busy_in [*3];
    endsequence

    AST_SDA_ONLY_LOW: assert property (@(posedge clk_in) disable iff (rst_in)
        sda_out == 1'h0) else $error("sda driven high");
    AST_OE_CHANGES_ON_FALL: assert property (@(negedge scl_in) disable iff (rst_in)
        sda_oe_out == oe_rise_r) else $error("sda drive changed while scl high");
    AST_PROTECT_STICKY: assert property (@(posedge clk_in) disable iff (rst_in)
        protect_reg_out |=> protect_reg_out) else $error("protect register cleared");
    AST_WRITE_PERMISSION: assert property (@(posedge clk_in) disable iff (rst_in)
        write_allowed_out == !($past(protect_pin_in, 2) || (WP_MODE && protect_reg_out)))
        else $error("write permission wrong");
    AST_REQ_HELD_PROGRAM: assert property (@(posedge clk_in) disable iff (rst_in)
        req_during_program |=> flash_access_request_out) else $error("request dropped early");
    AST_REQ_DROP_IDLE: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(flash_access_request_out) |-> !$past(program_busy_in))
        else $error("request dropped during program");
    AST_BUSY_SILENT: assert property (@(posedge clk_in) disable iff (rst_in)
        program_running |-> !sda_oe_out) else $error("sda driven during program");
    AST_READ_WRAP: assert property (@(posedge scl_in) disable iff (rst_in)
        $changed(read_addr_out) && $past(read_addr_out[6:0]) == 7'h7F |->
        read_addr_out == {$past(read_addr_out[ADDR_W-1:7]), 7'h00})
        else $error("read address left its page");
endmodule : eeprom_emul_chk

bind eeprom_emul_protect_arbiter eeprom_emul_chk #(.WP_MODE(WP_MODE), .ADDR_W(ADDR_W))
    i_eeprom_emul_chk (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .protect_pin_in(protect_pin_in),
    .flash_access_request_out(flash_access_request_out), .program_busy_in(program_busy_in),
    .read_addr_out(read_addr_out), .write_allowed_out(write_allowed_out),
    .protect_reg_out(protect_reg_out));
`default_nettype wire

// ---- test/serial_master_model.sv ----
// two-wire serial master: link clock and open-drain data pull-down
// assumes: data line pulled up outside; scl stands high between frames
`timescale 1ns/1ps
`default_nettype none

module serial_master_model
#(
    parameter int GAP_NS = 600
)
(
    // link
    output logic      scl_out,
    output logic      sda_low_out,
    input  wire logic sda_in
);
    initial
    begin
        scl_out     = 1'h1;
        sda_low_out = 1'h0;
    end
    // a long low phase leaves the arbiter time to grant before the ack slot
    task automatic bit_out(input logic b, input int wait_ns);
        sda_low_out = !b;
        #(3 + wait_ns);
        scl_out = 1'h1;
        #6;
        scl_out = 1'h0;
        #3;
    endtask : bit_out
    task automatic bit_in(output logic b, input int wait_ns);
        sda_low_out = 1'h0;
        #(3 + wait_ns);
        scl_out = 1'h1;
        b = sda_in;
        #6;
        scl_out = 1'h0;
        #3;
    endtask : bit_in
    task automatic start_cond();
        sda_low_out = 1'h0;
        #3;
        scl_out = 1'h1;
        #3;
        sda_low_out = 1'h1;
        #3;
        scl_out = 1'h0;
        #3;
    endtask : start_cond
    task automatic stop_cond();
        sda_low_out = 1'h1;
        #3;
        scl_out = 1'h1;
        #3;
        sda_low_out = 1'h0;
        #6;
    endtask : stop_cond
    task automatic recover();
        repeat (9) bit_out(1'h1, 0);
    endtask : recover
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i], GAP_NS);
        bit_in(b, GAP_NS);
        ack = (b === 1'h0);
    endtask : wr_byte
    task automatic rd_byte(output logic [7:0] d, input logic give_ack);
        for (int i = 7; i >= 0; i--) bit_in(d[i], 0);
        bit_out(!give_ack, 0);
    endtask : rd_byte
endmodule : serial_master_model
`default_nettype wire

// ---- test/eeprom_emul_protect_arbiter_tb.sv ----
// self-checking bench with serial master, flash and arbiter stand-ins
// assumes: design in software protect mode, device select tied to 2
`timescale 1ns/1ps
`default_nettype none

module eeprom_emul_protect_arbiter_tb;
    localparam int AW = eeprom_emul_pkg::ADDR_W;
    logic          clk_in;
    logic          rst_in;
    logic          scl_in;
    logic          sda_in;
    logic          sda_out;
    logic          sda_oe_out;
    logic          sda_low;
    logic          protect_pin_in;
    logic          flash_access_request_out;
    logic          flash_access_grant_in = 1'h0;
    logic          program_busy_in;
    logic          grant_en;
    logic [7:0]    read_data_in;
    logic [AW-1:0] read_addr_out;
    logic          write_allowed_out;
    logic          protect_reg_out;
    int            errors = 0;
    int            check_count = 0;

    eeprom_emul_protect_arbiter #(.WP_MODE(1'h1), .ADDR_W(AW)) i_eeprom_emul_protect_arbiter
    (
        .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .dev_select_in(3'h2), .protect_pin_in(protect_pin_in),
        .flash_access_request_out(flash_access_request_out),
        .flash_access_grant_in(flash_access_grant_in), .program_busy_in(program_busy_in),
        .read_data_in(read_data_in), .read_addr_out(read_addr_out),
        .write_allowed_out(write_allowed_out), .protect_reg_out(protect_reg_out)
    );
    serial_master_model i_serial_master_model
        (.scl_out(scl_in), .sda_low_out(sda_low), .sda_in(sda_in));

    // flash pattern differs at every page offset but repeats in every page, so a missed wrap reads the same data
    assign read_data_in = {1'h0, read_addr_out[6:0]} ^ 8'hC3;
    assign sda_in = (sda_oe_out ? sda_out : 1'h1) & !sda_low;
    always @(posedge clk_in) flash_access_grant_in <= #1 flash_access_request_out & grant_en;

    initial
    begin
        clk_in = 1'h0;
        forever #50 clk_in = !clk_in;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    task automatic check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check_bit
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check_byte
    task automatic cmd(input logic [3:0] pfx, input logic [2:0] sel, input logic rw,
                       input logic exp);
        logic ack;
        i_serial_master_model.start_cond();
        i_serial_master_model.wr_byte({pfx, sel, rw}, ack);
        check_bit("control ack", exp, ack);
    endtask : cmd
    task automatic wr(input logic [7:0] d, input logic exp);
        logic ack;
        i_serial_master_model.wr_byte(d, ack);
        check_bit("data ack", exp, ack);
    endtask : wr
    task automatic stop();
        i_serial_master_model.stop_cond();
    endtask : stop
    task automatic wait_req_low();
        for (int i = 0; i < 50 && flash_access_request_out === 1'h1; i++) step(1);
        check_bit("request released", 1'h0, flash_access_request_out);
    endtask : wait_req_low
    task automatic read_one(input logic exp);
        logic [7:0] d;
        cmd(4'h6, 3'h2, 1'h1, exp);
        if (exp)
            i_serial_master_model.rd_byte(d, 1'h0);
        stop();
        wait_req_low();
    endtask : read_one

    task automatic t_reset_state();
        check_bit("sda drive", 1'h0, sda_oe_out);
        check_bit("request", 1'h0, flash_access_request_out);
        check_bit("protect register", 1'h0, protect_reg_out);
        check_bit("write allowed", 1'h1, write_allowed_out);
    endtask : t_reset_state
    task automatic t_foreign_and_no_grant();
        cmd(4'hA, 3'h5, 1'h0, 1'h0);
        stop();
        step(2);
        check_bit("request", 1'h0, flash_access_request_out);
        grant_en = 1'h0;
        cmd(4'hA, 3'h2, 1'h1, 1'h0);
        stop();
        grant_en = 1'h1;
        wait_req_low();
    endtask : t_foreign_and_no_grant
    task automatic t_seq_read();
        logic [7:0] d;
        cmd(4'hA, 3'h2, 1'h1, 1'h1);
        for (int k = 0; k < 130; k++)
        begin
            i_serial_master_model.rd_byte(d, k != 129);
            check_byte("read byte", {1'h0, 7'(k)} ^ 8'hC3, d);
        end
        stop();
        wait_req_low();
    endtask : t_seq_read
    task automatic t_write_program();
        cmd(4'hA, 3'h2, 1'h0, 1'h1);
        wr(8'h10, 1'h1);
        wr(8'h5A, 1'h1);
        stop();
        step(3);
        check_bit("request after write", 1'h1, flash_access_request_out);
        program_busy_in = 1'h1;
        step(3);
        i_serial_master_model.recover();
        cmd(4'hA, 3'h2, 1'h0, 1'h0);
        stop();
        check_bit("request while programming", 1'h1, flash_access_request_out);
        step(10);
        program_busy_in = 1'h0;
        wait_req_low();
        cmd(4'hA, 3'h2, 1'h1, 1'h1);
        read_one_tail();
    endtask : t_write_program
    task automatic read_one_tail();
        logic [7:0] d;
        i_serial_master_model.rd_byte(d, 1'h0);
        stop();
        wait_req_low();
    endtask : read_one_tail
    task automatic t_pin();
        protect_pin_in = 1'h1;
        step(2);
        check_bit("write allowed", 1'h0, write_allowed_out);
        cmd(4'hA, 3'h2, 1'h0, 1'h1);
        wr(8'h30, 1'h1);
        stop();
        step(1);
        protect_pin_in = 1'h0;
        wait_req_low();
        check_bit("write allowed", 1'h1, write_allowed_out);
    endtask : t_pin
    task automatic t_protect();
        read_one(1'h1);
        cmd(4'h6, 3'h2, 1'h0, 1'h1);
        wr(8'h00, 1'h1);
        wr(8'hFF, 1'h1);
        stop();
        step(3);
        check_bit("protect register", 1'h1, protect_reg_out);
        check_bit("write allowed", 1'h0, write_allowed_out);
        program_busy_in = 1'h1;
        step(5);
        program_busy_in = 1'h0;
        wait_req_low();
        read_one(1'h0);
        cmd(4'h6, 3'h2, 1'h0, 1'h0);
        stop();
        wait_req_low();
        cmd(4'hA, 3'h2, 1'h0, 1'h1);
        wr(8'h20, 1'h1);
        stop();
        step(2);
        check_bit("write allowed", 1'h0, write_allowed_out);
    endtask : t_protect

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        #5000000;
        errors++;
        print_verdict();
    end
    initial
    begin
        rst_in = 1'h1;
        protect_pin_in = 1'h0;
        program_busy_in = 1'h0;
        grant_en = 1'h1;
        i_serial_master_model.recover();
        step(10);
        rst_in = 1'h0;
        step(2);
        t_reset_state();
        t_foreign_and_no_grant();
        t_seq_read();
        t_write_program();
        t_pin();
        t_protect();
        print_verdict();
    end
endmodule : eeprom_emul_protect_arbiter_tb
`default_nettype wire
